// *** verilog/clock_and_buzzer_output.sv ***
// Purpose: Clock pin and buzzer outputs with their select and port registers
// Assumes: Ticks arrive at twice the peripheral and subsystem clock rates
// Notes:   Register reads answer one cycle after the read strobe
`timescale 1ns/1ns
module clock_and_buzzer_output
  import clkbuz_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        prs_half_tick,
  input  wire logic        sub_half_tick,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_bit_wr,
  input  wire logic [2:0]  cpu_bit_sel,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_rd,
  output logic      [7:0]  cpu_rdata,
  input  wire logic        buzzer_pin_in,
  output logic             buzzer_pin_out,
  output logic             buzzer_pin_oe,
  input  wire logic        clock_pin_in,
  output logic             programmable_clock_pin_out,
  output logic             programmable_clock_pin_oe
);
  import clkbuz_pkg::*;

  typedef struct packed {
    logic [7:0] output_clock_select;
    logic [7:0] pm3;
    logic [7:0] pm1;
    logic [7:0] p3;
    logic [7:0] p1;
    logic [7:0] rdata;
    logic       pcl_run;
    logic       buz_out;
    logic       buz_oe;
    logic       pcl_out;
    logic       pcl_oe;
  } ctl_state_s;

  ctl_state_s               st_reg;
  ctl_state_s               st_next;
  logic                     buz_wave;
  logic                     pcl_wave;
  logic [DIV_CNT_W-1:0]     buz_count;
  logic [DIV_CNT_W-1:0]     buz_limit;
  logic [DIV_CNT_W-1:0]     pcl_limit;
  logic [DIV_CNT_W-1:0]     pcl_count;
  logic                     pcl_div_run;
  logic                     pcl_tick;
  logic                     buzzer_output_enable;
  logic                     clock_pin_enable;
  logic [1:0]               buzzer_rate_select;
  logic [3:0]               pin_clock_rate_select;
  logic                     hit_cks;
  logic                     hit_pm3;
  logic                     hit_pm1;
  logic                     hit_p3;
  logic                     hit_p1;

  assign buzzer_output_enable  = st_reg.output_clock_select[BUZ_EN_BIT];
  assign clock_pin_enable      = st_reg.output_clock_select[PCL_EN_BIT];
  assign buzzer_rate_select    = st_reg.output_clock_select[BUZ_SEL_LSB +: 2];
  assign pin_clock_rate_select = st_reg.output_clock_select[PCL_SEL_LSB +: 4];

  assign hit_cks = (cpu_addr == ADDR_CKS);
  assign hit_pm3 = (cpu_addr == ADDR_PM3);
  assign hit_pm1 = (cpu_addr == ADDR_PM1);
  assign hit_p3  = (cpu_addr == ADDR_P3);
  assign hit_p1  = (cpu_addr == ADDR_P1);

  // Rate fields are used live; software keeps them still while enabled
  assign buz_limit = half_limit(4'(BUZ_BASE_SHIFT + {2'b00, buzzer_rate_select}));
  // Codes above 8 are prohibited; they behave as the subsystem clock
  assign pcl_tick  = pin_clock_rate_select[PCL_SUB_BIT] ? sub_half_tick : prs_half_tick;
  assign pcl_limit = pin_clock_rate_select[PCL_SUB_BIT] ? half_limit(4'h0)
                   : half_limit({1'b0, pin_clock_rate_select[2:0]});
  // Halt at once when disabled and low; one spare tick would start a runt high
  assign pcl_div_run = st_reg.pcl_run && (clock_pin_enable || pcl_wave);

  wave_divider #(.CNT_W(DIV_CNT_W)) u_buz_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (buzzer_output_enable),
    .tick    (prs_half_tick),
    .limit   (buz_limit),
    .wave    (buz_wave),
    .count   (buz_count)
  );

  wave_divider #(.CNT_W(DIV_CNT_W)) u_pcl_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (pcl_div_run),
    .tick    (pcl_tick),
    .limit   (pcl_limit),
    .wave    (pcl_wave),
    .count   (pcl_count)
  );

  always_comb begin
    st_next = st_reg;
    // Register writes, byte or single bit
    st_next.output_clock_select = apply_write(st_reg.output_clock_select, cpu_wr && hit_cks, cpu_bit_wr && hit_cks,
                              cpu_bit_sel, cpu_wdata);
    st_next.pm3 = apply_write(st_reg.pm3, cpu_wr && hit_pm3, cpu_bit_wr && hit_pm3,
                              cpu_bit_sel, cpu_wdata) | PM3_FIXED_ONES;
    st_next.pm1 = apply_write(st_reg.pm1, cpu_wr && hit_pm1, cpu_bit_wr && hit_pm1,
                              cpu_bit_sel, cpu_wdata);
    st_next.p3  = apply_write(st_reg.p3, cpu_wr && hit_p3, cpu_bit_wr && hit_p3,
                              cpu_bit_sel, cpu_wdata);
    st_next.p1  = apply_write(st_reg.p1, cpu_wr && hit_p1, cpu_bit_wr && hit_p1,
                              cpu_bit_sel, cpu_wdata);

    // Reads; the buzzer and clock port bits return the pin in input mode
    st_next.rdata = UNMAPPED_READ;
    if (cpu_rd) begin
      if (hit_cks) begin
        st_next.rdata = st_reg.output_clock_select;
      end else if (hit_pm3) begin
        st_next.rdata = st_reg.pm3;
      end else if (hit_pm1) begin
        st_next.rdata = st_reg.pm1;
      end else if (hit_p3) begin
        st_next.rdata = st_reg.p3;
        if (st_reg.pm3[BUZ_PORT_BIT]) begin
          st_next.rdata[BUZ_PORT_BIT] = buzzer_pin_in;
        end
      end else if (hit_p1) begin
        st_next.rdata = st_reg.p1;
        if (st_reg.pm1[PCL_PORT_BIT]) begin
          st_next.rdata[PCL_PORT_BIT] = clock_pin_in;
        end
      end
    end

    // Run starts only with the divider at low; stop waits for the high half to end
    st_next.pcl_run = clock_pin_enable || (st_reg.pcl_run && pcl_wave);

    // Latch ORed with the function; latch must be 0 for a clean wave
    st_next.buz_out = st_reg.p3[BUZ_PORT_BIT] | buz_wave;
    st_next.pcl_out = st_reg.p1[PCL_PORT_BIT] | pcl_wave;
    st_next.buz_oe  = ~st_reg.pm3[BUZ_PORT_BIT];
    st_next.pcl_oe  = ~st_reg.pm1[PCL_PORT_BIT];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg       <= '0;
      st_reg.output_clock_select   <= CKS_RESET;
      st_reg.pm3   <= DIR_RESET;
      st_reg.pm1   <= DIR_RESET;
      st_reg.p3    <= LATCH_RESET;
      st_reg.p1    <= LATCH_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cpu_rdata                  = st_reg.rdata;
  assign buzzer_pin_out             = st_reg.buz_out;
  assign buzzer_pin_oe              = st_reg.buz_oe;
  assign programmable_clock_pin_out = st_reg.pcl_out;
  assign programmable_clock_pin_oe  = st_reg.pcl_oe;

  // Checks
  sequence s_pcl_idle;
    !clock_pin_enable && !pcl_wave;
  endsequence

  a_buz_off_low: assert property (@(posedge clk) disable iff (sys_rst)
    !buzzer_output_enable |=> !buz_wave)
    else $error("buzzer wave not low while disabled");

  a_buz_count_bound: assert property (@(posedge clk) disable iff (sys_rst)
    buzzer_output_enable |-> buz_count <= buz_limit)
    else $error("buzzer divider count beyond limit");

  a_pcl_idle_low: assert property (@(posedge clk) disable iff (sys_rst)
    s_pcl_idle ##1 !clock_pin_enable |-> !pcl_wave)
    else $error("clock wave moved while disabled");

  a_cks_reset_zero: assert property (@(posedge clk)
    sys_rst |=> st_reg.output_clock_select == CKS_RESET)
    else $error("select register not cleared by reset");

  a_bit_write_keep: assert property (@(posedge clk) disable iff (sys_rst)
    (cpu_bit_wr && !cpu_wr && hit_cks) |=>
      st_reg.output_clock_select[$past(cpu_bit_sel)] == $past(cpu_wdata[0]) &&
      ((st_reg.output_clock_select ^ $past(st_reg.output_clock_select)) & ~(8'h01 << $past(cpu_bit_sel))) == 8'h00)
    else $error("bit write disturbed other select bits");

  a_pin_buffer_dir: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 (buzzer_pin_oe == ~$past(st_reg.pm3[BUZ_PORT_BIT])) &&
        (programmable_clock_pin_oe == ~$past(st_reg.pm1[PCL_PORT_BIT])))
    else $error("pin buffer does not follow direction bit");

  a_dir_reset_ones: assert property (@(posedge clk)
    sys_rst |=> st_reg.pm3 == DIR_RESET && st_reg.pm1 == DIR_RESET)
    else $error("direction registers not set by reset");

  a_pcl_start_low: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st_reg.pcl_run) |-> !pcl_wave && pcl_count == '0)
    else $error("clock pin started from a high level");

  a_pcl_stop_full: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(st_reg.pcl_run) |-> !$past(pcl_wave) && $past(st_reg.pcl_run, 2))
    else $error("clock pin stopped inside a high period");

  a_buz_restart_low: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(buzzer_output_enable) |-> !buz_wave && buz_count == '0)
    else $error("buzzer divider not reset before restart");

endmodule : clock_and_buzzer_output

// *** pkg/clkbuz_pkg.sv ***
// Purpose: Shared constants for the clock output and buzzer output block
// Assumes: 16-bit register addresses, 8-bit registers
// Notes:   Divider periods are counted in half-period ticks of each source clock
package clkbuz_pkg;

  localparam int          DIV_CNT_W        = 13;

  // Register addresses
  localparam logic [15:0] ADDR_CKS         = 16'hFF40;
  localparam logic [15:0] ADDR_PM3         = 16'hFF23;
  localparam logic [15:0] ADDR_PM1         = 16'hFF21;
  localparam logic [15:0] ADDR_P3          = 16'hFF03;
  localparam logic [15:0] ADDR_P1          = 16'hFF01;

  // Reset values, fixed PM3 bits and the unmapped read value
  localparam logic [7:0]  CKS_RESET        = 8'h00;
  localparam logic [7:0]  DIR_RESET        = 8'hFF;
  localparam logic [7:0]  LATCH_RESET      = 8'h00;
  localparam logic [7:0]  PM3_FIXED_ONES   = 8'hE0;
  localparam logic [7:0]  UNMAPPED_READ    = 8'h00;

  // Select register fields
  localparam int          BUZ_EN_BIT       = 7;
  localparam int          BUZ_SEL_LSB      = 5;
  localparam int          PCL_EN_BIT       = 4;
  localparam int          PCL_SEL_LSB      = 0;
  localparam int          PCL_SUB_BIT      = 3;

  // Pin positions inside their ports
  localparam int          BUZ_PORT_BIT     = 3;
  localparam int          PCL_PORT_BIT     = 0;

  // Buzzer divides by two to the power BUZ_BASE_SHIFT plus the select field
  localparam logic [3:0]  BUZ_BASE_SHIFT   = 4'hA;

  // Half-period count limit for a divide by two to the power shift
  function automatic logic [DIV_CNT_W-1:0] half_limit(input logic [3:0] shift);
    logic [DIV_CNT_W:0] full;
    full = (14'h0001 << shift) - 14'h0001;
    return full[DIV_CNT_W-1:0];
  endfunction : half_limit

  // Byte write or single-bit write onto an 8-bit register
  function automatic logic [7:0] apply_write(input logic [7:0] old, input logic byte_wr,
                                             input logic bit_wr, input logic [2:0] sel,
                                             input logic [7:0] wdata);
    logic [7:0] v;
    v = old;
    if (byte_wr) begin
      v = wdata;
    end else if (bit_wr) begin
      v[sel] = wdata[0];
    end
    return v;
  endfunction : apply_write

endpackage : clkbuz_pkg

// *** verilog/wave_divider.sv ***
// Purpose: Square-wave divider toggling after a programmable count of ticks
// Assumes: tick is a one-cycle pulse at twice the source clock rate
// Notes:   Dropping run clears the counter and the wave in the next cycle
`timescale 1ns/1ns
module wave_divider #(
  parameter int CNT_W = 13
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  wave,
  output logic      [CNT_W-1:0] count
);

  typedef struct packed {
    logic             wave;
    logic [CNT_W-1:0] cnt;
  } div_state_s;

  div_state_s div_reg;
  div_state_s div_next;

  always_comb begin
    div_next = div_reg;
    if (!run) begin
      div_next = '0;
    end else if (tick) begin
      if (div_reg.cnt >= limit) begin
        div_next.cnt  = '0;
        div_next.wave = ~div_reg.wave;
      end else begin
        div_next.cnt = div_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign wave  = div_reg.wave;
  assign count = div_reg.cnt;

endmodule : wave_divider

// *** testbench/pin_load_model.sv ***
// Purpose: Load model on one output pin, measuring its high and low widths
// Assumes: Pull-down on the line, so a released pin reads low
// Notes:   Widths are in clk cycles, taken at each level change
`timescale 1ns/1ns
module pin_load_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  output logic             pin_level,
  output logic      [15:0] last_high,
  output logic      [15:0] last_low
);
  logic        prev_level;
  logic [15:0] run_len;
  // Released line goes to the pull-down level, never a stale value
  assign pin_level = pin_oe ? pin_out : 1'b0;
  always @(posedge clk) begin
    prev_level <= pin_level;
    if (sys_rst) begin
      run_len <= 16'h0001;
      last_high <= 16'h0000;
      last_low <= 16'h0000;
    end else if (pin_level != prev_level) begin
      if (prev_level) begin
        last_high <= run_len;
      end else begin
        last_low <= run_len;
      end
      run_len <= 16'h0001;
    end else begin
      run_len <= run_len + 16'h0001;
    end
  end
endmodule : pin_load_model

// *** testbench/clock_and_buzzer_output_tb_top.sv ***
// Purpose: Self-checking bench for the clock pin and buzzer outputs
// Assumes: Peripheral ticks every 2 cycles, subsystem ticks every 6
// Notes:   Long buzzer periods dominate the run time
`timescale 1ns/1ns
module clock_and_buzzer_output_tb_top;
  import clkbuz_pkg::*;
  logic        clk, sys_rst, prs_half_tick, sub_half_tick;
  logic [15:0] cpu_addr;
  logic        cpu_wr, cpu_bit_wr, cpu_rd;
  logic [2:0]  cpu_bit_sel, tcnt;
  logic [7:0]  cpu_wdata, cpu_rdata, rv;
  logic        bz_out, bz_oe, bz_lvl, ck_out, ck_oe, ck_lvl;
  logic [15:0] bz_hi, bz_lo, ck_hi, ck_lo;
  int          bad_count, checked, i, code;
  clock_and_buzzer_output dut (.clk(clk), .sys_rst(sys_rst), .prs_half_tick(prs_half_tick),
    .sub_half_tick(sub_half_tick), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_bit_wr(cpu_bit_wr), .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .buzzer_pin_in(bz_lvl), .buzzer_pin_out(bz_out),
    .buzzer_pin_oe(bz_oe), .clock_pin_in(ck_lvl), .programmable_clock_pin_out(ck_out),
    .programmable_clock_pin_oe(ck_oe));
  pin_load_model bz_load (.clk(clk), .sys_rst(sys_rst), .pin_out(bz_out), .pin_oe(bz_oe),
    .pin_level(bz_lvl), .last_high(bz_hi), .last_low(bz_lo));
  pin_load_model ck_load (.clk(clk), .sys_rst(sys_rst), .pin_out(ck_out), .pin_oe(ck_oe),
    .pin_level(ck_lvl), .last_high(ck_hi), .last_low(ck_lo));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      tcnt <= 3'h0;
      prs_half_tick <= 1'b0;
      sub_half_tick <= 1'b0;
    end else begin
      tcnt <= (tcnt == 3'h5) ? 3'h0 : tcnt + 3'h1;
      prs_half_tick <= tcnt[0];
      sub_half_tick <= (tcnt == 3'h5);
    end
  end
  // Half period in clk cycles, from the tick spacing above
  function automatic logic [15:0] half_cyc(input logic buzzer_pin, input int c);
    if (buzzer_pin) return 16'h0001 << (11 + c);
    if (c == 8) return 16'h0006;
    return 16'h0002 << c;
  endfunction : half_cyc
  task automatic results();
    $display("checks=%0d errors=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_len(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t width=%h exp=%h", $time, got, exp);
    end
  endtask : chk_len
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic bwr(input logic [15:0] a, input logic [2:0] b, input logic v);
    cpu_addr <= a;
    cpu_bit_sel <= b;
    cpu_wdata <= {7'h00, v};
    cpu_bit_wr <= 1'b1;
    @(posedge clk);
    cpu_bit_wr <= 1'b0;
    @(posedge clk);
  endtask : bwr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    // Read data stands for the one cycle after the strobe
    @(posedge clk);
    d = cpu_rdata;
  endtask : rd
  // Bounded wait for a pin level; runs out into the closing report
  task automatic wait_lvl(input logic ck, input logic v);
    for (int n = 0; n < 40000; n++) begin
      @(posedge clk);
      if ((ck ? ck_out : bz_out) === v) return;
    end
    bad_count++;
    results();
  endtask : wait_lvl
  initial begin
    sys_rst = 1'b1;
    {cpu_addr, cpu_wr, cpu_bit_wr, cpu_rd, cpu_bit_sel, cpu_wdata} = 30'h00000000;
    bad_count = 0;
    checked = 0;
    void'($urandom(32'h7070da2a));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk_reg({4'h0, bz_oe, ck_oe, bz_out, ck_out}, 8'h00);
    rd(ADDR_CKS, rv);
    chk_reg(rv, 8'h00);
    rd(ADDR_PM3, rv);
    chk_reg(rv, 8'hFF);
    rd(ADDR_PM1, rv);
    chk_reg(rv, 8'hFF);
    wr(16'hFF50, 8'h5A);
    rd(16'hFF50, rv);
    chk_reg(rv, 8'h00);
    // Input-mode bit reads the pulled-down pin, not the latch
    wr(ADDR_P3, 8'hAD);
    rd(ADDR_P3, rv);
    chk_reg(rv, 8'hA5);
    wr(ADDR_P3, 8'hA5);
    wr(ADDR_PM3, 8'hF7);
    code = $urandom;
    wr(ADDR_PM1, code[7:0] & 8'hFE);
    rd(ADDR_PM1, rv);
    chk_reg(rv, code[7:0] & 8'hFE);
    chk_reg({6'h00, bz_oe, ck_oe}, 8'h03);
    bwr(ADDR_CKS, 3'h7, 1'b1);
    rd(ADDR_CKS, rv);
    chk_reg(rv, 8'h80);
    bwr(ADDR_CKS, 3'h7, 1'b0);
    rd(ADDR_CKS, rv);
    chk_reg(rv, 8'h00);
    for (i = 0; i < 4; i++) begin
      // Stop first so the rate field never moves while enabled
      bwr(ADDR_CKS, 3'h7, 1'b0);
      wr(ADDR_CKS, {1'b0, i[1:0], 5'h00});
      wr(ADDR_CKS, {1'b1, i[1:0], 5'h00});
      wait_lvl(1'b0, 1'b1);
      wait_lvl(1'b0, 1'b0);
      @(posedge clk);
      chk_len(bz_hi, half_cyc(1'b1, i));
    end
    wr(ADDR_CKS, 8'h60);
    repeat (3) @(posedge clk);
    chk_reg({7'h00, bz_out}, 8'h00);
    repeat (5000) @(posedge clk);
    chk_reg({7'h00, bz_out}, 8'h00);
    // Corners first, then random codes; no low-supply fast oscillator is modelled
    for (i = 0; i < 6; i++) begin
      code = (i == 0) ? 0 : (i == 1) ? 8 : $urandom_range(7, 1);
      wr(ADDR_CKS, code[7:0]);
      wr(ADDR_CKS, 8'h10 | code[7:0]);
      wait_lvl(1'b1, 1'b1);
      wait_lvl(1'b1, 1'b0);
      wait_lvl(1'b1, 1'b1);
      wr(ADDR_CKS, code[7:0]);
      wait_lvl(1'b1, 1'b0);
      @(posedge clk);
      chk_len(ck_lo, half_cyc(1'b0, code));
      chk_len(ck_hi, half_cyc(1'b0, code));
      repeat (300) @(posedge clk);
      chk_reg({7'h00, ck_out}, 8'h00);
    end
    results();
  end
endmodule : clock_and_buzzer_output_tb_top
